// ---- rtl/periph_flags_pkg.sv ----
package periph_flags_pkg;

  // ************************************************************
  // Register map, byte addresses on the register bus.
  // ************************************************************
  localparam logic [4:0] ADDR_REQUEST = 5'h00;
  localparam logic [4:0] ADDR_RESET_CAUSE = 5'h04;
  localparam logic [4:0] ADDR_PIN_STEER = 5'h08;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h0c;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h10;
  // Held in place of a write address whose upper bits are not zero.
  localparam logic [4:0] ADDR_UNMAPPED = 5'h03;

  // ************************************************************
  // Field positions and implemented-bit masks.
  // ************************************************************
  localparam int BIT_ADC = 6;
  localparam int BIT_CCP = 5;
  localparam int BIT_CMP = 3;
  localparam int BIT_TMR2 = 1;
  localparam int BIT_TIMER_ONE_COUNT = 0;
  localparam logic [7:0] REQ_MASK_FULL = 8'h6b;
  localparam logic [7:0] REQ_MASK_SMALL = 8'h09;
  localparam int BIT_POWER_ON = 1;
  localparam int BIT_BROWN_OUT = 0;
  localparam int BIT_BOR_ENABLE = 7;
  localparam logic [7:0] CAUSE_MASK = 8'h83;
  localparam int BIT_GATE_SEL = 4;
  localparam int BIT_PWM_B_SEL = 1;
  localparam int BIT_PWM_A_SEL = 0;
  localparam logic [7:0] STEER_MASK = 8'h13;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ************************************************************
  // Capture/compare unit modes.
  // ************************************************************
  localparam logic [1:0] CCP_OFF = 2'h0;
  localparam logic [1:0] CCP_CAPTURE = 2'h1;
  localparam logic [1:0] CCP_COMPARE = 2'h2;
  localparam logic [1:0] CCP_PWM = 2'h3;

  // ************************************************************
  // Bus responses.
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- rtl/pin_steer.sv ----
`timescale 1ns/100ps
`default_nettype none

module pin_steer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] steer,
  input wire logic gate_on_master_clear_pin_pin,
  input wire logic gate_on_osc_pin,
  input wire logic pwm_a,
  input wire logic pwm_b,
  output logic timer_one_gate,
  output logic osc_pin_pwm,
  output logic data_pin_pwm,
  output logic clkin_pin_pwm,
  output logic int_pin_pwm
);

  // ************************************************************
  // Routing of gate input and PWM outputs.
  // ************************************************************
  wire logic gsel = steer[periph_flags_pkg::BIT_GATE_SEL];
  wire logic bsel = steer[periph_flags_pkg::BIT_PWM_B_SEL];
  wire logic asel = steer[periph_flags_pkg::BIT_PWM_A_SEL];

  // Registered so that every pin output comes from a flip-flop.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_one_gate <= 1'b0;
      osc_pin_pwm <= 1'b0;
      data_pin_pwm <= 1'b0;
      clkin_pin_pwm <= 1'b0;
      int_pin_pwm <= 1'b0;
    end else begin
      timer_one_gate <= gsel ? gate_on_master_clear_pin_pin : gate_on_osc_pin;
      osc_pin_pwm <= bsel & pwm_b;
      data_pin_pwm <= ~bsel & pwm_b;
      clkin_pin_pwm <= asel & pwm_a;
      int_pin_pwm <= ~asel & pwm_a;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/periph_flags_reset_cause_pin_steer.sv ----
// How it works
// - Flags set on events regardless of enables.
// - Converter-done flag reads one after conversion.
// - Capture mode: capture sets sticky flag.
// - Compare mode: match sets sticky flag.
// - Comparator change sets sticky flag.
// - Timer-two period match sets sticky flag.
// - Timer-one overflow sets sticky flag.
// - Unimplemented and absent-peripheral bits read zero.
// - Power-on bit cleared by power-on reset.
// - Brown-out bit cleared by brown-out reset.
// - Brown-out bit reads zero when detection off.
// - Reset-cause register holds brown-out detect enable.
// - Gate select picks master-clear or oscillator pin.
// - PWM B select picks oscillator or data pin.
// - PWM A select picks clock-in or interrupt pin.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

module periph_flags_reset_cause_pin_steer #(
  parameter bit FULL_VARIANT = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic adc_done,
  input wire logic [1:0] ccp_mode,
  input wire logic ccp_capture,
  input wire logic ccp_match,
  input wire logic comparator_out,
  input wire logic timer_two_match,
  input wire logic timer_one_overflow,
  input wire logic power_on_event,
  input wire logic brown_out_event,
  input wire logic gate_on_master_clear_pin_pin,
  input wire logic gate_on_osc_pin,
  input wire logic pwm_a,
  input wire logic pwm_b,
  output logic timer_one_gate,
  output logic osc_pin_pwm,
  output logic data_pin_pwm,
  output logic clkin_pin_pwm,
  output logic int_pin_pwm,
  output logic brown_out_detect_en,
  output logic irq
);

  // ************************************************************
  // Helpers.
  // ************************************************************

  // Merges a write byte into a register under the writable mask.
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wr,
                                       input logic [7:0] msk);
    merge = (old & ~msk) | (wr & msk);
  endfunction

  // ************************************************************
  // State.
  // ************************************************************
  logic [7:0] req_r, req_nxt;
  logic [7:0] cause_r, cause_nxt;
  logic [7:0] steer_r;
  logic [7:0] mask_r;
  logic [7:0] stat_r, stat_nxt;
  logic cmp_prev_r;
  logic cmp_seen_r;
  logic aw_hold_r, w_hold_r;
  logic [4:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic w_lane_r;

  // ************************************************************
  // Event decode.
  // ************************************************************
  wire logic [7:0] req_mask = FULL_VARIANT ? periph_flags_pkg::REQ_MASK_FULL
                                           : periph_flags_pkg::REQ_MASK_SMALL;
  wire logic cmp_change = cmp_seen_r & (comparator_out != cmp_prev_r);
  wire logic ccp_event = ((ccp_mode == periph_flags_pkg::CCP_CAPTURE) & ccp_capture)
                       | ((ccp_mode == periph_flags_pkg::CCP_COMPARE) & ccp_match);
  // PWM and off modes contribute nothing to the flag.
  wire logic [7:0] req_set = {1'b0, adc_done, ccp_event, 1'b0, cmp_change, 1'b0,
                              timer_two_match, timer_one_overflow} & req_mask;

  // ************************************************************
  // Write channel handling.
  // ************************************************************
  // Both halves are latched first, so a write lands once and only from held values.
  wire logic [4:0] wa = aw_addr_r;
  wire logic [7:0] wd = w_data_r;
  wire logic wl = w_lane_r;
  wire logic wr_go = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  wire logic wr_hi_ok = s_axi_awaddr[31:5] == 27'h0000000;
  wire logic wr_fire = wr_go & wl;
  wire logic wr_req = wr_fire & (wa == periph_flags_pkg::ADDR_REQUEST);
  wire logic wr_cause = wr_fire & (wa == periph_flags_pkg::ADDR_RESET_CAUSE);
  wire logic wr_steer = wr_fire & (wa == periph_flags_pkg::ADDR_PIN_STEER);
  wire logic wr_mask = wr_fire & (wa == periph_flags_pkg::ADDR_IRQ_MASK);
  wire logic wr_known = (wa == periph_flags_pkg::ADDR_REQUEST)
                      | (wa == periph_flags_pkg::ADDR_RESET_CAUSE)
                      | (wa == periph_flags_pkg::ADDR_PIN_STEER)
                      | (wa == periph_flags_pkg::ADDR_IRQ_MASK)
                      | (wa == periph_flags_pkg::ADDR_IRQ_STATUS);

  // ************************************************************
  // Read decode.
  // ************************************************************
  wire logic rd_go = s_axi_arvalid & s_axi_arready;
  wire logic [4:0] ra = s_axi_araddr[4:0];
  wire logic rd_hi_ok = s_axi_araddr[31:5] == 27'h0000000;
  wire logic bor_on = cause_r[periph_flags_pkg::BIT_BOR_ENABLE];
  wire logic [7:0] cause_view = {cause_r[7:1],
                                 cause_r[periph_flags_pkg::BIT_BROWN_OUT] & bor_on};
  wire logic rd_known = (ra == periph_flags_pkg::ADDR_REQUEST)
                      | (ra == periph_flags_pkg::ADDR_RESET_CAUSE)
                      | (ra == periph_flags_pkg::ADDR_PIN_STEER)
                      | (ra == periph_flags_pkg::ADDR_IRQ_MASK)
                      | (ra == periph_flags_pkg::ADDR_IRQ_STATUS);
  wire logic [7:0] rd_byte =
      (ra == periph_flags_pkg::ADDR_REQUEST) ? (req_r & req_mask) :
      (ra == periph_flags_pkg::ADDR_RESET_CAUSE) ? cause_view :
      (ra == periph_flags_pkg::ADDR_PIN_STEER) ? steer_r :
      (ra == periph_flags_pkg::ADDR_IRQ_MASK) ? mask_r :
      (ra == periph_flags_pkg::ADDR_IRQ_STATUS) ? stat_r : 8'h00;
  wire logic rd_stat = rd_go & rd_hi_ok & (ra == periph_flags_pkg::ADDR_IRQ_STATUS);

  // ************************************************************
  // Next-state values; hardware sets win over software writes.
  // ************************************************************
  assign req_nxt = (wr_req ? merge(req_r, wd, req_mask) : req_r) | req_set;
  assign cause_nxt = {(wr_cause ? merge(cause_r, wd, periph_flags_pkg::CAUSE_MASK) : cause_r)
                      & ~{6'h00, power_on_event, brown_out_event}};
  assign stat_nxt = (rd_stat ? 8'h00 : stat_r) | req_set;

  // Flag, cause and interrupt state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_r <= periph_flags_pkg::RESET_BYTE;
      cause_r <= periph_flags_pkg::RESET_BYTE;
      steer_r <= periph_flags_pkg::RESET_BYTE;
      mask_r <= periph_flags_pkg::RESET_BYTE;
      stat_r <= periph_flags_pkg::RESET_BYTE;
      cmp_prev_r <= 1'b0;
      cmp_seen_r <= 1'b0;
      irq <= 1'b0;
      brown_out_detect_en <= 1'b0;
    end else begin
      req_r <= req_nxt;
      cause_r <= cause_nxt;
      if (wr_steer) begin
        steer_r <= merge(steer_r, wd, periph_flags_pkg::STEER_MASK);
      end
      if (wr_mask) begin
        mask_r <= merge(mask_r, wd, req_mask);
      end
      stat_r <= stat_nxt;
      cmp_prev_r <= comparator_out;
      cmp_seen_r <= 1'b1;
      irq <= |(stat_nxt & mask_r);
      brown_out_detect_en <= cause_nxt[periph_flags_pkg::BIT_BOR_ENABLE];
    end
  end

  // ************************************************************
  // AXI4-Lite write side.
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 5'h00;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= periph_flags_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid & ~aw_hold_r & ~s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= wr_hi_ok ? s_axi_awaddr[4:0] : periph_flags_pkg::ADDR_UNMAPPED;
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid & ~w_hold_r & ~s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
        s_axi_wready <= 1'b1;
      end
      if (wr_go & aw_hold_r & w_hold_r) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? periph_flags_pkg::RESP_OKAY : periph_flags_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read side.
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= periph_flags_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_hi_ok ? rd_byte : 8'h00};
        s_axi_rresp <= (rd_hi_ok & rd_known) ? periph_flags_pkg::RESP_OKAY
                                             : periph_flags_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Pin steering.
  // ************************************************************
  pin_steer u_steer (
    .aclk(aclk),
    .aresetn(aresetn),
    .steer(steer_r),
    .gate_on_master_clear_pin_pin(gate_on_master_clear_pin_pin),
    .gate_on_osc_pin(gate_on_osc_pin),
    .pwm_a(pwm_a),
    .pwm_b(pwm_b),
    .timer_one_gate(timer_one_gate),
    .osc_pin_pwm(osc_pin_pwm),
    .data_pin_pwm(data_pin_pwm),
    .clkin_pin_pwm(clkin_pin_pwm),
    .int_pin_pwm(int_pin_pwm)
  );

endmodule

`default_nettype wire

// ---- tb/periph_flags_properties.sv ----
`timescale 1ns/100ps
`default_nettype none

module periph_flags_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic gate_on_master_clear_pin_pin,
  input wire logic gate_on_osc_pin,
  input wire logic pwm_a,
  input wire logic pwm_b,
  input wire logic timer_one_gate,
  input wire logic osc_pin_pwm,
  input wire logic data_pin_pwm,
  input wire logic clkin_pin_pwm,
  input wire logic int_pin_pwm,
  input wire logic brown_out_detect_en,
  input wire logic irq
);
  // ****************************************
  // Port checks
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [3:0] rd_addr_r;

  // Remembers the low four bits of the offset of the read in flight.
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_r <= s_axi_araddr[3:0];
    end
  end

  gate_src_a: assert property (timer_one_gate |-> $past(gate_on_master_clear_pin_pin) || $past(gate_on_osc_pin))
    else $error("gate output has no source pin");
  pwm_b_pin_a: assert property (osc_pin_pwm || data_pin_pwm |-> $past(pwm_b) && !(osc_pin_pwm && data_pin_pwm))
    else $error("pwm b on wrong pins");
  pwm_a_pin_a: assert property (clkin_pin_pwm || int_pin_pwm |-> $past(pwm_a) && !(clkin_pin_pwm && int_pin_pwm))
    else $error("pwm a on wrong pins");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  req_unused_a: assert property (s_axi_rvalid && rd_addr_r == 4'h0 |-> (s_axi_rdata[7:0] & 8'h94) == 8'h00)
    else $error("unused flag bits set");
  cause_unused_a: assert property (s_axi_rvalid && rd_addr_r == 4'h4 |-> s_axi_rdata[6:2] == 5'h00)
    else $error("unused cause bits set");
  bor_off_a: assert property (s_axi_rvalid && rd_addr_r == 4'h4 && !brown_out_detect_en |-> !s_axi_rdata[0])
    else $error("brown-out bit read while detect off");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  reset_out_a: assert property ($rose(aresetn) |-> !irq && !s_axi_rvalid && !brown_out_detect_en && !timer_one_gate)
    else $error("outputs not clear after reset");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && rd_addr_r == 4'h8);
  cover property ($rose(irq));
endmodule

bind periph_flags_reset_cause_pin_steer periph_flags_props u_props (.aclk, .aresetn,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .s_axi_bvalid, .s_axi_bready, .gate_on_master_clear_pin_pin, .gate_on_osc_pin, .pwm_a, .pwm_b,
  .timer_one_gate, .osc_pin_pwm, .data_pin_pwm, .clkin_pin_pwm, .int_pin_pwm,
  .brown_out_detect_en, .irq);

`default_nettype wire

// ---- tb/tb_periph_flags_reset_cause_pin_steer.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); \
  end \
end

module tb_periph_flags_reset_cause_pin_steer;
  // ****************************************
  // Signals and unit
  // ****************************************
  logic aclk, aresetn;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, ccp_mode;
  logic adc_done, ccp_capture, ccp_match, comparator_out, timer_two_match, timer_one_overflow;
  logic power_on_event, brown_out_event, gate_on_master_clear_pin_pin, gate_on_osc_pin, pwm_a, pwm_b;
  logic timer_one_gate, osc_pin_pwm, data_pin_pwm, clkin_pin_pwm, int_pin_pwm;
  logic brown_out_detect_en, irq;
  logic [7:0] e;
  int errors, checked;
  int pos[5] = '{0, 1, 5, 5, 6};
  localparam logic [1:0] OK = periph_flags_pkg::RESP_OKAY;
  localparam logic [1:0] ER = periph_flags_pkg::RESP_SLVERR;

  periph_flags_reset_cause_pin_steer #(.FULL_VARIANT(1'b1)) uut (.*);

  // Free-running core clock.
  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;

  // ****************************************
  // Bus tasks
  // ****************************************
  // One write; address and data are held until each is taken.
  task automatic wr(input logic [31:0] a, input logic [7:0] x, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, x};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    `CHK("bvalid", 1'b1, s_axi_bvalid)
    `CHK("bresp", er, s_axi_bresp)
  endtask

  // One read, compared with the expected byte and response.
  task automatic chk(input logic [31:0] a, input logic [7:0] x, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    `CHK("rvalid", 1'b1, s_axi_rvalid)
    `CHK("rdata", x, s_axi_rdata[7:0])
    `CHK("rresp", er, s_axi_rresp)
  endtask

  // One-cycle pulse on event input b.
  task automatic ev(input int b);
    @(posedge aclk);
    {power_on_event, brown_out_event, adc_done, ccp_capture, ccp_match, timer_two_match,
     timer_one_overflow} <= 7'h01 << b;
    @(posedge aclk);
    {power_on_event, brown_out_event, adc_done, ccp_capture, ccp_match, timer_two_match,
     timer_one_overflow} <= 7'h00;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    conclude();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {aresetn, s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awvalid, s_axi_wvalid,
     s_axi_bready, s_axi_arvalid, s_axi_rready, ccp_mode, adc_done, ccp_capture, ccp_match,
     comparator_out, timer_two_match, timer_one_overflow, power_on_event, brown_out_event,
     gate_on_master_clear_pin_pin, gate_on_osc_pin, pwm_a, pwm_b} = '0;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 20; a += 4) chk(a, 8'h00, OK);
    chk(32'h14, 8'h00, ER);
    chk(32'h100, 8'h00, ER);
    wr(32'h14, 8'hff, ER);
    $display("reset and map done");
    wr(0, 8'hff, OK);
    chk(0, 8'h6b, OK);
    for (int b = 0; b < 5; b++) begin
      wr(0, 8'h00, OK);
      ccp_mode <= (b == 3) ? periph_flags_pkg::CCP_CAPTURE : periph_flags_pkg::CCP_COMPARE;
      ev(b);
      chk(0, 8'h01 << pos[b], OK);
    end
    wr(0, 8'h00, OK);
    comparator_out <= 1'b1;
    chk(0, 8'h08, OK);
    chk(0, 8'h08, OK);
    wr(0, 8'h00, OK);
    chk(0, 8'h00, OK);
    ccp_mode <= periph_flags_pkg::CCP_PWM;
    ev(2);
    ev(3);
    chk(0, 8'h00, OK);
    $display("flags done");
    chk(32'h10, 8'h6b, OK);
    chk(32'h10, 8'h00, OK);
    wr(32'hc, 8'h01, OK);
    chk(32'hc, 8'h01, OK);
    ev(0);
    repeat (3) @(posedge aclk);
    `CHK("irq", 1'b1, irq)
    wr(32'hc, 8'h00, OK);
    repeat (3) @(posedge aclk);
    `CHK("irq", 1'b0, irq)
    chk(32'h10, 8'h01, OK);
    chk(32'h10, 8'h00, OK);
    $display("irq done");
    wr(4, 8'hff, OK);
    chk(4, 8'h83, OK);
    `CHK("bor_en", 1'b1, brown_out_detect_en)
    ev(5);
    chk(4, 8'h82, OK);
    ev(6);
    chk(4, 8'h80, OK);
    wr(4, 8'h03, OK);
    chk(4, 8'h02, OK);
    $display("reset cause done");
    s_axi_wstrb <= 4'he;
    wr(8, 8'h13, OK);
    s_axi_wstrb <= 4'hf;
    chk(8, 8'h00, OK);
    gate_on_master_clear_pin_pin <= 1'b1;
    pwm_a <= 1'b1;
    pwm_b <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      e = {3'h0, k[2], 2'h0, k[1], k[0]};
      wr(8, e, OK);
      chk(8, e, OK);
      `CHK("gate", e[4], timer_one_gate)
      `CHK("pwm_b", {e[1], !e[1]}, {osc_pin_pwm, data_pin_pwm})
      `CHK("pwm_a", {e[0], !e[0]}, {clkin_pin_pwm, int_pin_pwm})
    end
    $display("steering done");
    conclude();
  end
endmodule

`default_nettype wire
